/* osc_out_regs.vh */
// Constants for the divided oscillator output stage and its register slave.
// Included by bare name; holds definitions only.
`ifndef OSC_OUT_REGS_VH
`define OSC_OUT_REGS_VH

// Register byte offsets on the AXI4-Lite slave.
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_PHASE 12'h008

// Control register fields.
`define CTRL_OVR_BIT 0
`define CTRL_CODE_LSB 4
`define CTRL_CODE_MSB 7
`define CTRL_RESET 32'h00000000

// Status register fields.
`define STAT_RUN_BIT 0
`define STAT_OUT_BIT 1
`define STAT_HOLD_BIT 2
`define STAT_POL_BIT 3
`define STAT_APP_LSB 4
`define STAT_APP_MSB 7
`define STAT_FILT_LSB 8
`define STAT_FILT_MSB 11
`define STAT_FVALID_BIT 12

// AXI response codes.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Timing counts in master clock periods.
`define START_CYCLES 500
`define FILTER_CYCLES 16
// Log2 of half the fixed divider of 1024.
`define HALF_FIXED_LOG 9
// Each divider step multiplies the ratio by eight.
`define RATIO_STEP_LOG 3

`endif

/* code_filter.v */
// Digital settling filter for a sampled multi-bit code.
// Assumes din is already synchronous to clk.
`timescale 1ns/100ps
`include "osc_out_regs.vh"
module code_filter #(
	parameter W = 4,
	parameter N = `FILTER_CYCLES,
	parameter CW = 6
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Raw code in
	input wire [W-1:0] din,
	// Settled code out
	output reg [W-1:0] dout,
	output reg valid
);
	reg [W-1:0] last;
	reg [CW-1:0] stable;

	always @(posedge clk) begin
		if (!rst_n) begin
			last <= {W{1'b0}};
			stable <= {CW{1'b0}};
			dout <= {W{1'b0}};
			valid <= 1'b0;
		end else begin
			last <= din;
			if (din != last) begin
				stable <= {CW{1'b0}};
			end else if (stable != N[CW-1:0] - 1'b1) begin
				stable <= stable + 1'b1;
			end else begin
				// A code only passes after N equal samples in a row.
				dout <= din;
				valid <= 1'b1;
			end
		end
	end
endmodule // code_filter

/* divided_oscillator_output.v */
// Output stage of a divided low-frequency oscillator with hold and polarity,
// plus an AXI4-Lite register slave for status and a code override.
// Assumes clk is the free-running master oscillator and rst_n is the
// power-on reset; output_hold and divider_code arrive asynchronously.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "osc_out_regs.vh"

// Function
// - Polarity 0: hold is active high, output not inverted, held low.
// - Polarity 1: hold is active low, output inverted, held high.
// - Latch clocked once per divided event; hold resets or holds it.
// - Polarity 0: after release, rising edge comes at next event with beat low, on the free-running grid.
// - Polarity 1: after release, falling edge comes at next event with beat low, on the free-running grid.
// - Oscillator and divider keep running unchanged while held.
// - Only power-on reset realigns pulse phase; hold never does.
// - Code keeps being sampled; a change applies at the next event after the filter passes it.
// - Code changes switch glitch-free; no pulse below one master period.
// - Sampled code is filtered and applied only once stable.
// - Start-up lasts 500 master periods with the output held low.
// - Output enabled only once a valid code is resolved.
// - Polarity 0 start: oscillate if not held, else skip pulses.
// - Polarity 1 start: go high, fall one master period later.
// - Polarity 1 start with hold active: stay high in reset.
// - Code MSB is polarity; low codes ratio 8^k, high codes mirrored.
// - Fixed divide by 1024 then the programmable ratio.
module divided_oscillator_output #(
	parameter HALF_LOG = `HALF_FIXED_LOG,
	parameter START_CYCLES = `START_CYCLES,
	parameter FILTER_CYCLES = `FILTER_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// AXI4-Lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Pins
	input wire output_hold,
	input wire [3:0] divider_code,
	output reg osc_out
);
	localparam ST_START = 3'b001;
	localparam ST_FIRST = 3'b010;
	localparam ST_RUN = 3'b100;

	// Pin synchronisers.
	reg hold_meta;
	reg hold_sync;
	reg [3:0] code_meta;
	reg [3:0] code_sync;

	// Oscillator state.
	reg [31:0] phase;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [9:0] start_cnt;
	reg latch;
	reg next_latch;
	reg beat;
	reg [3:0] applied_code;
	reg [3:0] next_applied_code;

	// Register slave state.
	reg [31:0] ctrl;
	reg aw_full;
	reg [11:0] aw_addr;
	reg w_full;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire [3:0] filt_code;
	wire filt_valid;
	wire [3:0] code_src;
	wire polarity_select;
	wire hold_act;
	wire [2:0] ratio_idx;
	wire [4:0] half_bits;
	wire [31:0] half_mask;
	wire div_event;
	wire start_done;
	wire [31:0] status;
	reg [31:0] read_mux;
	reg [1:0] read_resp;

	always @(posedge clk) begin
		if (!rst_n) begin
			hold_meta <= 1'b0;
			hold_sync <= 1'b0;
			code_meta <= 4'h0;
			code_sync <= 4'h0;
		end else begin
			hold_meta <= output_hold;
			hold_sync <= hold_meta;
			code_meta <= divider_code;
			code_sync <= code_meta;
		end
	end

	// Software may override the pin code; the filter still sees the source.
	assign code_src = ctrl[`CTRL_OVR_BIT] ?
		ctrl[`CTRL_CODE_MSB:`CTRL_CODE_LSB] : code_sync;

	code_filter #(
		.W(4),
		.N(FILTER_CYCLES),
		.CW(6)
	) u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.din(code_src),
		.dout(filt_code),
		.valid(filt_valid)
	);

	assign polarity_select = applied_code[3];
	assign ratio_idx = applied_code[3] ? ~applied_code[2:0] :
		applied_code[2:0];

	assign hold_act = polarity_select ? ~hold_sync : hold_sync;

	assign half_bits = HALF_LOG[4:0] +
		{ratio_idx, 1'b0} + {2'b00, ratio_idx};
	assign half_mask = ~(32'hFFFFFFFF << half_bits);
	assign div_event = (phase & half_mask) == half_mask;

	always @(posedge clk) begin
		if (!rst_n) begin
			phase <= 32'h00000000;
		end else begin
			phase <= phase + 32'h00000001;
		end
	end

	// Event parity runs free, so a held latch rejoins the original pulse grid.
	always @(posedge clk) begin
		if (!rst_n) begin
			beat <= 1'b0;
		end else if (div_event) begin
			beat <= ~beat;
		end
	end

	assign start_done = start_cnt == START_CYCLES[9:0] - 10'h001;

	always @(posedge clk) begin
		if (!rst_n) begin
			start_cnt <= 10'h000;
		end else if (state == ST_START && !start_done) begin
			start_cnt <= start_cnt + 10'h001;
		end
	end

	always @* begin
		next_state = state;
		next_latch = latch;
		next_applied_code = applied_code;
		case (state)
			ST_START: begin
				next_latch = 1'b0;
				if (start_done && filt_valid) begin
					next_applied_code = filt_code;
					if (filt_code[3]) begin
						next_state = ST_FIRST;
					end else begin
						next_state = ST_RUN;
					end
				end
			end
			ST_FIRST: begin
				// fall one master period after going high
				if (hold_act) begin
					next_latch = 1'b0;
				end else begin
					next_latch = 1'b1;
				end
				next_state = ST_RUN;
			end
			ST_RUN: begin
				if (hold_act) begin
					next_latch = 1'b0;
				end else if (div_event) begin
					next_latch = ~beat;
				end
				// switch only on an event boundary
				if (div_event && filt_code != applied_code) begin
					next_applied_code = filt_code;
				end
			end
			default: begin
				next_state = ST_START;
				next_latch = 1'b0;
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_START;
			latch <= 1'b0;
			applied_code <= 4'h0;
			osc_out <= 1'b0;
		end else begin
			state <= next_state;
			latch <= next_latch;
			applied_code <= next_applied_code;
			if (next_state == ST_START) begin
				osc_out <= 1'b0;
			end else begin
				osc_out <= next_latch ^ next_applied_code[3];
			end
		end
	end

	assign status = {19'h00000, filt_valid, filt_code, applied_code,
		polarity_select, hold_act, osc_out, state != ST_START};

	// Write side: address and data are taken in either order.
	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;

	always @(posedge clk) begin
		if (!rst_n) begin
			aw_full <= 1'b0;
			aw_addr <= 12'h000;
			w_full <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			ctrl <= `CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_full && w_full && !s_axi_bvalid) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == `REG_CTRL) begin
					s_axi_bresp <= `RESP_OKAY;
					// Only the low byte holds fields.
					if (w_strb[0]) begin
						ctrl <= {24'h000000,
							w_data[`CTRL_CODE_MSB:`CTRL_CODE_LSB],
							3'b000, w_data[`CTRL_OVR_BIT]};
					end
				end else if (aw_addr == `REG_STATUS ||
					aw_addr == `REG_PHASE) begin
					// Read-only registers ignore writes.
					s_axi_bresp <= `RESP_OKAY;
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		read_mux = 32'h00000000;
		read_resp = `RESP_OKAY;
		case (s_axi_araddr)
			`REG_CTRL: read_mux = ctrl;
			`REG_STATUS: read_mux = status;
			`REG_PHASE: read_mux = phase;
			default: read_resp = `RESP_SLVERR;
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_mux;
			s_axi_rresp <= read_resp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // divided_oscillator_output

/* osc_out_checker_properties.sv */
// Checker for the divided oscillator output, on the top's ports only.
// Assumes rst_n is synchronous, active low, in the clk domain.
`timescale 1ns/100ps
module osc_out_checker #(
	parameter START_CYCLES = 500
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic output_hold,
	input wire logic [3:0] divider_code,
	input wire logic osc_out,
	// Bus handshakes
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Saturates so a long run never wraps back into start-up.
	logic [15:0] cnt;
	wire up = cnt > START_CYCLES + 4;
	always @(posedge clk) begin
		if (!rst_n)
			cnt <= 16'h0;
		else if (cnt != 16'hFFFF)
			cnt <= cnt + 16'h1;
	end
	property p_start; cnt < START_CYCLES - 1 |-> !osc_out; endproperty
	a_start: assert property (p_start) else $error("early output");
	property p_low;
		(!divider_code[3] && output_hold) [*6] |-> !osc_out;
	endproperty
	a_low: assert property (p_low) else $error("not held low");
	property p_high;
		(up && divider_code[3] && !output_hold) [*6] |-> osc_out;
	endproperty
	a_high: assert property (p_high) else $error("not held high");
	property p_blip;
		!up && divider_code[3] && output_hold && $rose(osc_out) |=> !osc_out;
	endproperty
	a_blip: assert property (p_blip) else $error("bad first pulse");
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("bvalid stuck");
	property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rdone: assert property (p_rdone) else $error("rvalid stuck");
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rans: assert property (p_rans) else $error("late read data");
	property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rblk: assert property (p_rblk) else $error("second read taken");
endmodule // osc_out_checker

bind divided_oscillator_output osc_out_checker #(
	.START_CYCLES(START_CYCLES)
) chk (
	.clk(clk),
	.rst_n(rst_n),
	.output_hold(output_hold),
	.divider_code(divider_code),
	.osc_out(osc_out),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

/* hold_source.sv */
// Model of the outside logic that drives the hold pin.
// Assumes the bench changes want just after a rising edge.
`timescale 1ns/100ps
module hold_source (
	// Clock
	input wire logic clk,
	// Bench request and pin
	input wire logic want,
	output logic output_hold = 1'b0
);
	always @(posedge clk) begin
		output_hold <= want;
	end
endmodule // hold_source

/* resettable_divided_oscillator_output_tb.sv */
// Self-checking bench for the divided oscillator output stage.
// Assumes the design, its header and the checker compile first.
`timescale 1ns/100ps
`include "osc_out_regs.vh"
module resettable_divided_oscillator_output_tb;
	localparam int START = 40;
	logic clk = 0, rst_n = 0, hold_req = 0;
	logic [3:0] divider_code = 4'h0, s_axi_wstrb = 4'hF;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, output_hold, osc_out;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int fails = 0, checks_done = 0, cyc = 0;
	// Short half period keeps the two lowest ratios in reach of the run.
	divided_oscillator_output #(.HALF_LOG(2), .START_CYCLES(START)) dut (
		.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.output_hold(output_hold), .divider_code(divider_code),
		.osc_out(osc_out)
	);
	hold_source src (.clk(clk), .want(hold_req), .output_hold(output_hold));
	always #12.5 clk = ~clk;
	task check(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %h %h", $time, got, exp);
		end
	endtask
	task close_out;
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic axi_w(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic pa = 1, pw = 1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (pa || pw) begin
			@(posedge clk);
			if (s_axi_awready) pa = 0;
			if (s_axi_wready) pw = 0;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task axi_r(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task wait_edge(input logic e, output int t);
		do @(negedge clk); while (osc_out !== ~e);
		do @(negedge clk); while (osc_out !== e);
		t = cyc;
	endtask
	task automatic start_seq(input logic [3:0] c, input logic h);
		int fr = 0, nh = 0;
		@(posedge clk);
		divider_code <= c;
		hold_req <= h;
		rst_n <= 0;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		for (int i = 1; i <= 120; i++) begin
			@(negedge clk);
			if (osc_out === 1'b1 && fr == 0)
				fr = i;
			nh += (osc_out === 1'b1);
		end
		check(fr == 0 || fr >= START, 1);
		if (c[3] == h)
			check(nh > 30, 1);
		else
			check(nh, c[3] ? 121 - fr : 0);
	endtask
	task phase_seq(input logic [3:0] c);
		int t1, t2;
		start_seq(c, c[3]);
		wait_edge(~c[3], t1);
		@(posedge clk);
		hold_req <= ~c[3];
		repeat (13) @(posedge clk);
		hold_req <= c[3];
		wait_edge(~c[3], t2);
		check((t2 - t1) % 8, 0);
		check(t2 - t1 > 16, 1);
	endtask
	task code_seq;
		int t1, t2;
		@(posedge clk);
		divider_code <= 4'h1;
		repeat (5) @(posedge clk);
		divider_code <= 4'h0;
		wait_edge(1, t1);
		wait_edge(1, t2);
		check(t2 - t1, 8);
		@(posedge clk);
		divider_code <= 4'h1;
		repeat (300) @(posedge clk);
		wait_edge(1, t1);
		wait_edge(1, t2);
		check(t2 - t1, 64);
	endtask
	task reg_seq;
		logic [31:0] d;
		logic [1:0] r;
		axi_r(`REG_CTRL, d, r);
		check(d, `CTRL_RESET);
		axi_w(`REG_CTRL, 32'h000000F0, r);
		axi_r(`REG_CTRL, d, r);
		check(d, 32'h000000F0);
		axi_r(`REG_STATUS, d, r);
		check(d & 32'h00001FFD, 32'h00001111);
		axi_w(12'h00C, 32'h0, r);
		check(r, `RESP_SLVERR);
		axi_r(12'h00C, d, r);
		check(r, `RESP_SLVERR);
	endtask
	initial begin
		start_seq(4'h0, 1'b1);
		start_seq(4'h8, 1'b0);
		phase_seq(4'hF);
		phase_seq(4'h0);
		code_seq;
		reg_seq;
		close_out;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			close_out;
		end
	end
endmodule // resettable_divided_oscillator_output_tb
